// *** core/ubie_core.sv ***
// Purpose: one bulk/interrupt endpoint, standard or ping-pong, IN or OUT
// Assumes: link side is packet logic on mclk_in; firmware side is strobes
// Notes:   status outputs lag the internal state by one cycle
`timescale 1ns/1ps
`include "ubie_map.svh"

// Function
// - bulk and interrupt handled identically
// - valid OUT sets bank-zero flag
// - byte count loaded, zero for ZLP
// - standard OUT NAKs while flag set
// - overflow bytes dropped, count includes them
// - ping-pong OUT flags alternate per packet
// - clearing flag switches firmware bank
// - ping-pong NAK only when both banks full
// - transmit-ready sends stored data next IN
// - ready with empty FIFO sends ZLP
// - IN NAKed until transmit-ready set
// - clearing ready cancels and empties FIFO only while idle with no IN token
// - acknowledged IN sets transmit-complete
// - retries handled without firmware
// - ping-pong ready switches firmware bank
// - per-bank NAK and per-bank completion
// - data read advances pointer, count untouched
module ubie_core #(
	parameter int DEPTH = `UBIE_DEPTH,
	parameter int CW    = `UBIE_CNT_W
) (
	input  wire logic                  mclk_in,
	input  wire logic                  sys_rst_in,
	input  wire logic                  ep_en_in,
	input  wire logic                  dir_in_in,
	input  wire logic                  ping_pong_in,
	input  wire logic                  fw_wr_in,
	input  wire logic [7:0]            fw_wdata_in,
	input  wire logic                  fw_rd_in,
	input  wire logic                  fw_clr_rx0_in,
	input  wire logic                  fw_clr_rx1_in,
	input  wire logic                  fw_set_tx_packet_ready_in,
	input  wire logic                  fw_clr_tx_packet_ready_in,
	input  wire logic                  fw_clr_txdone_in,
	output logic      [7:0]            fw_rdata_out,
	output ubie_pkg::ubie_flags_t      flags_out,
	output logic      [CW-1:0]         byte_cnt_out,
	input  wire logic                  out_tok_in,
	input  wire logic                  in_tok_in,
	input  wire logic                  rx_vld_in,
	input  wire logic [7:0]            rx_byte_in,
	input  wire logic                  rx_end_in,
	input  wire logic                  rx_crc_ok_in,
	input  wire logic                  host_ack_in,
	input  wire logic                  host_tmo_in,
	input  wire logic                  tx_ready_in,
	output ubie_pkg::ubie_hs_t         hs_out,
	output logic                       tx_vld_out,
	output logic      [7:0]            tx_data_out,
	output logic                       tx_eop_out
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

	ubie_pkg::ubie_state_t st_ff;
	logic [7:0]         mem [0:2*DEPTH-1];
	logic [1:0]         busy_ff;
	logic [1:0]         tx_rdy_ff;
	logic [1:0]         tx_done_ff;
	logic [1:0][CW-1:0] cnt_ff;
	logic [1:0][AW:0]   tx_len_ff;
	logic [CW-1:0]      run_ff;
	logic [AW:0]        fw_ptr_ff;
	logic [AW:0]        tx_idx_ff;
	logic               fw_bank_ff;
	logic               usb_bank_ff;
	logic               rx_bank_ff;
	logic               tog_ff;
	logic               pick_bank;
	logic               pick_ok;
	logic               out_go;
	logic               in_go;
	logic               rx_ok;
	logic               tx_ack;
	logic               cancel;

	// bulk and interrupt share every path below; type is never consulted
	// same handling
	assign out_go = (st_ff == ubie_pkg::ST_IDLE) && out_tok_in && ep_en_in && !dir_in_in;
	assign in_go  = (st_ff == ubie_pkg::ST_IDLE) && in_tok_in && ep_en_in && dir_in_in;
	assign rx_ok  = (st_ff == ubie_pkg::ST_RX) && rx_end_in && rx_crc_ok_in;
	assign tx_ack = (st_ff == ubie_pkg::ST_WACK) && host_ack_in;
	// a packet in flight is not cancelled under the link's feet
	assign cancel = fw_clr_tx_packet_ready_in && dir_in_in && (st_ff == ubie_pkg::ST_IDLE) && !in_tok_in;

	always_comb begin
		pick_bank = usb_bank_ff;
		pick_ok   = !busy_ff[usb_bank_ff];
		if (!ping_pong_in) begin
			pick_bank = 1'b0;
			pick_ok   = !busy_ff[0];
		end else if (busy_ff[usb_bank_ff] && !busy_ff[!usb_bank_ff]) begin
			pick_bank = !usb_bank_ff;
			pick_ok   = 1'b1;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			st_ff       <= ubie_pkg::ST_IDLE;
			usb_bank_ff <= `UBIE_BANK_RST;
			rx_bank_ff  <= `UBIE_BANK_RST;
			tog_ff      <= 1'b0;
			run_ff      <= '0;
			tx_idx_ff   <= '0;
		end else begin
			case (st_ff)
				ubie_pkg::ST_IDLE: begin
					if (out_go && pick_ok) begin
						st_ff      <= ubie_pkg::ST_RX;
						rx_bank_ff <= pick_bank;
						run_ff     <= '0;
					end else if (in_go && tx_rdy_ff[usb_bank_ff]) begin
						st_ff     <= ubie_pkg::ST_TX;
						tx_idx_ff <= '0;
					end
				end
				ubie_pkg::ST_RX: begin
					if (rx_vld_in)
						run_ff <= run_ff + CW'(1);
					if (rx_end_in) begin
						st_ff <= ubie_pkg::ST_IDLE;
						if (rx_crc_ok_in) begin
							tog_ff <= !tog_ff;
							if (ping_pong_in)
								usb_bank_ff <= !rx_bank_ff;
						end
					end
				end
				ubie_pkg::ST_TX: begin
					if (tx_idx_ff == tx_len_ff[usb_bank_ff])
						st_ff <= ubie_pkg::ST_WACK;
					else if (tx_ready_in)
						tx_idx_ff <= tx_idx_ff + (AW+1)'(1);
				end
				ubie_pkg::ST_WACK: begin
					if (host_ack_in) begin
						st_ff  <= ubie_pkg::ST_IDLE;
						tog_ff <= !tog_ff;
						if (ping_pong_in)
							usb_bank_ff <= !usb_bank_ff;
					end else if (host_tmo_in) begin
						st_ff <= ubie_pkg::ST_IDLE;
					end
				end
				default: st_ff <= ubie_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			hs_out <= '0;
		end else begin
			hs_out <= '0;
			if (out_go && !pick_ok)
				hs_out <= '{valid: 1'b1, pid: `UBIE_PID_NAK};
			else if (in_go && !tx_rdy_ff[usb_bank_ff])
				hs_out <= '{valid: 1'b1, pid: `UBIE_PID_NAK};
			else if (in_go)
				hs_out <= '{valid: 1'b1, pid: tog_ff ? `UBIE_PID_DATA1 : `UBIE_PID_DATA0};
			else if (rx_ok)
				hs_out <= '{valid: 1'b1, pid: `UBIE_PID_ACK};
		end
	end

	// byte stream out; an empty bank gives just the eop
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			tx_vld_out  <= 1'b0;
			tx_data_out <= 8'h00;
			tx_eop_out  <= 1'b0;
		end else begin
			tx_vld_out <= 1'b0;
			tx_eop_out <= 1'b0;
			if (st_ff == ubie_pkg::ST_TX) begin
				if (tx_idx_ff == tx_len_ff[usb_bank_ff]) begin
					tx_eop_out <= 1'b1;
				end else if (tx_ready_in) begin
					tx_vld_out  <= 1'b1;
					tx_data_out <= mem[{usb_bank_ff, tx_idx_ff[AW-1:0]}];
				end
			end
		end
	end

	// overflow not stored; fw writes limited to capacity
	always_ff @(posedge mclk_in) begin
		if (st_ff == ubie_pkg::ST_RX && rx_vld_in && run_ff < CW'(DEPTH))
			mem[{rx_bank_ff, run_ff[AW-1:0]}] <= rx_byte_in;
		else if (fw_wr_in && dir_in_in && fw_ptr_ff < FULL)
			mem[{fw_bank_ff, fw_ptr_ff[AW-1:0]}] <= fw_wdata_in;
	end

	// receive flags; the set wins over a clear
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			busy_ff <= {2{`UBIE_FLAG_RST}};
		end else begin
			busy_ff <= busy_ff & ~{fw_clr_rx1_in, fw_clr_rx0_in};
			if (rx_ok)
				busy_ff[rx_bank_ff] <= 1'b1;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in)
			cnt_ff <= '0;
		else if (rx_ok)
			cnt_ff[rx_bank_ff] <= run_ff;
	end

	// completion per bank; set wins over clear
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			tx_done_ff <= {2{`UBIE_FLAG_RST}};
		end else begin
			if (fw_clr_txdone_in)
				tx_done_ff <= 2'b00;
			if (tx_ack)
				tx_done_ff[usb_bank_ff] <= 1'b1;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			tx_rdy_ff <= {2{`UBIE_FLAG_RST}};
			tx_len_ff <= '0;
		end else begin
			if (tx_ack)
				tx_rdy_ff[usb_bank_ff] <= 1'b0;
			if (cancel)
				tx_rdy_ff <= 2'b00;
			else if (fw_set_tx_packet_ready_in && dir_in_in) begin
				tx_rdy_ff[fw_bank_ff] <= 1'b1;
				tx_len_ff[fw_bank_ff] <= fw_ptr_ff;
			end
		end
	end

	// firmware-side bank and pointer
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			fw_bank_ff   <= `UBIE_BANK_RST;
			fw_ptr_ff    <= '0;
			fw_rdata_out <= 8'h00;
		end else if (!dir_in_in) begin
			if (fw_rd_in) begin
				fw_rdata_out <= mem[{fw_bank_ff, fw_ptr_ff[AW-1:0]}];
				if (fw_ptr_ff < FULL)
					fw_ptr_ff <= fw_ptr_ff + (AW+1)'(1);
			end
			if ((fw_clr_rx0_in && !fw_bank_ff) || (fw_clr_rx1_in && fw_bank_ff)) begin
				fw_ptr_ff <= '0;
				if (ping_pong_in)
					fw_bank_ff <= !fw_bank_ff;
			end
		end else begin
			if (cancel) begin
				fw_ptr_ff <= '0;
			end else if (fw_set_tx_packet_ready_in) begin
				fw_ptr_ff <= '0;
				if (ping_pong_in)
					fw_bank_ff <= !fw_bank_ff;
			end else if (fw_wr_in && fw_ptr_ff < FULL) begin
				fw_ptr_ff <= fw_ptr_ff + (AW+1)'(1);
			end
		end
	end

	// registered status view; flags cover both banks, byte count is from the selected firmware bank
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			flags_out    <= '0;
			byte_cnt_out <= '0;
		end else begin
			flags_out.rx0    <= busy_ff[0];
			flags_out.rx1    <= busy_ff[1];
			flags_out.tx_packet_ready  <= |tx_rdy_ff;
			flags_out.txdone <= |tx_done_ff;
			byte_cnt_out     <= dir_in_in ? CW'(fw_ptr_ff) : cnt_ff[fw_bank_ff];
		end
	end

	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (sys_rst_in);

	property p_std_nak;
		out_go && !ping_pong_in && busy_ff[0] |=> hs_out.valid && hs_out.pid == `UBIE_PID_NAK;
	endproperty
	a_std_nak: assert property (p_std_nak) else $error("busy bank 0 not NAKed");

	property p_pp_nak;
		out_go && ping_pong_in && !(busy_ff[0] && busy_ff[1]) |=> hs_out.pid != `UBIE_PID_NAK;
	endproperty
	a_pp_nak: assert property (p_pp_nak) else $error("NAK with a free bank");

	property p_rx_set;
		rx_ok |=> busy_ff[rx_bank_ff] && hs_out.pid == `UBIE_PID_ACK ##1 (flags_out.rx0 || flags_out.rx1);
	endproperty
	a_rx_set: assert property (p_rx_set) else $error("receive flag not set");

	property p_cnt;
		rx_ok |=> cnt_ff[rx_bank_ff] == $past(run_ff);
	endproperty
	a_cnt: assert property (p_cnt) else $error("byte count wrong");

	property p_rd_cnt;
		fw_rd_in && !rx_ok |=> $stable(cnt_ff);
	endproperty
	a_rd_cnt: assert property (p_rd_cnt) else $error("read changed count");

	property p_in_nak;
		in_go && !tx_rdy_ff[usb_bank_ff] |=> hs_out.pid == `UBIE_PID_NAK && st_ff == ubie_pkg::ST_IDLE;
	endproperty
	a_in_nak: assert property (p_in_nak) else $error("IN not NAKed");

	property p_done;
		tx_ack |=> tx_done_ff != 2'b00 ##1 flags_out.txdone;
	endproperty
	a_done: assert property (p_done) else $error("complete not set");

	property p_cancel;
		cancel |=> tx_rdy_ff == 2'b00 && fw_ptr_ff == '0;
	endproperty
	a_cancel: assert property (p_cancel) else $error("cancel failed");

	property p_retry;
		st_ff == ubie_pkg::ST_WACK && host_tmo_in && !host_ack_in && !cancel
			|=> tx_rdy_ff[usb_bank_ff];
	endproperty
	a_retry: assert property (p_retry) else $error("retry data lost");

	property p_switch;
		ping_pong_in && dir_in_in && fw_set_tx_packet_ready_in && !cancel |=> fw_bank_ff != $past(fw_bank_ff);
	endproperty
	a_switch: assert property (p_switch) else $error("bank not switched");
endmodule // ubie_core

// *** core/ubie_map.svh ***
// Purpose: constants for the bulk/interrupt endpoint engine
// Assumes: included by its bare name
// Notes:   definitions only
`ifndef UBIE_MAP_SVH
`define UBIE_MAP_SVH
`define UBIE_DEPTH     64
`define UBIE_CNT_W     16
`define UBIE_FLAG_RST  1'b0
`define UBIE_BANK_RST  1'b0
`define UBIE_PID_ACK   4'h2
`define UBIE_PID_NAK   4'ha
`define UBIE_PID_DATA0 4'h3
`define UBIE_PID_DATA1 4'hb
`endif

// *** core/ubie_pkg.sv ***
// Purpose: types for the bulk/interrupt endpoint engine
// Assumes: constants come from ubie_map.svh
// Notes:   nothing is imported by users
package ubie_pkg;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RX   = 2'b01,
		ST_TX   = 2'b11,
		ST_WACK = 2'b10
	} ubie_state_t;

	typedef struct packed {
		logic       valid;
		logic [3:0] pid;
	} ubie_hs_t;

	typedef struct packed {
		logic rx0;
		logic rx1;
		logic tx_packet_ready;
		logic txdone;
	} ubie_flags_t;
endpackage

// *** verif/ubie_host.sv ***
// Purpose: usb host model issuing bulk/interrupt tokens and data
// Assumes: drives just after the rising edge of mclk_in
// Notes:   idle data line shows the inverted last byte
`timescale 1ns/1ps
`include "ubie_map.svh"
module ubie_host (
	input  wire logic               mclk_in,
	input  wire ubie_pkg::ubie_hs_t hs_in,
	input  wire logic               tx_vld_in,
	input  wire logic [7:0]         tx_data_in,
	input  wire logic               tx_eop_in,
	output logic                    out_tok_out,
	output logic                    in_tok_out,
	output logic                    rx_vld_out,
	output logic [7:0]              rx_byte_out,
	output logic                    rx_end_out,
	output logic                    rx_crc_ok_out,
	output logic                    host_ack_out,
	output logic                    host_tmo_out,
	output logic                    tx_ready_out
);
	logic [7:0] txq[$];
	logic [7:0] got[$];
	logic [1:0] stall_ff = 2'h0;
	initial begin
		{out_tok_out, in_tok_out, rx_vld_out, rx_end_out} = 4'h0;
		{rx_crc_ok_out, host_ack_out, host_tmo_out, tx_ready_out} = 4'h1;
		rx_byte_out = 8'h00;
	end
	// slow link: one cycle in four has no room
	always @(posedge mclk_in) begin
		stall_ff <= stall_ff + 2'h1;
		tx_ready_out <= (stall_ff != 2'h3);
		if (tx_vld_in)
			got.push_back(tx_data_in);
	end
	task send_out(input logic crc);
		@(posedge mclk_in) out_tok_out <= 1'b1;
		@(posedge mclk_in) out_tok_out <= 1'b0;
		while (txq.size() > 0) begin
			rx_vld_out <= 1'b1;
			rx_byte_out <= txq.pop_front();
			@(posedge mclk_in);
		end
		rx_vld_out <= 1'b0;
		rx_byte_out <= ~rx_byte_out;
		rx_end_out <= 1'b1;
		rx_crc_ok_out <= crc;
		@(posedge mclk_in) rx_end_out <= 1'b0;
		rx_crc_ok_out <= ~crc;
	endtask
	task in_xfer(input logic ack, output logic nak, output logic hung);
		int k;
		nak = 1'b0;
		hung = 1'b0;
		got.delete();
		@(posedge mclk_in) in_tok_out <= 1'b1;
		@(posedge mclk_in) in_tok_out <= 1'b0;
		for (k = 0; k < 300; k++) begin
			@(posedge mclk_in);
			if (hs_in.valid && hs_in.pid == `UBIE_PID_NAK)
				nak = 1'b1;
			if (nak || tx_eop_in)
				break;
		end
		// no answer within the bound: the bench counts it as a hang
		hung = (k >= 300);
		if (!nak && !hung) begin
			host_ack_out <= ack;
			host_tmo_out <= ~ack;
			@(posedge mclk_in);
			host_ack_out <= 1'b0;
			host_tmo_out <= 1'b0;
		end
	endtask
endmodule // ubie_host

// *** verif/usb_bulk_int_endpoint_xfer_tb.sv ***
// Purpose: self-checking bench for ubie_core
// Assumes: host model on the link side, firmware strobes from here
// Notes:   expected data and handshakes kept in queues, data toggle in tog
`timescale 1ns/1ps
`include "ubie_map.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin errors++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module usb_bulk_int_endpoint_xfer_tb;
	logic mclk_in = 1'b0, sys_rst_in = 1'b1, ep_en = 1'b0, dir = 1'b0, pp = 1'b0;
	logic fw_wr = 1'b0, fw_rd = 1'b0, tog = 1'b0, nak;
	logic [4:0] fw_s = 5'h00;
	logic [7:0] fw_wdata = 8'h00, rdata, tx_data, rx_byte, e;
	logic [15:0] cnt;
	logic out_tok, in_tok, rx_vld, rx_end, crc, hack, htmo, txr, tx_vld, tx_eop;
	ubie_pkg::ubie_flags_t flags;
	ubie_pkg::ubie_hs_t hs;
	logic [31:0] seed = 32'h2ccb5321;
	logic [7:0] d[$], ex[$];
	logic [3:0] hsq[$];
	int errors = 0, n_tests = 0;
	always #4 mclk_in = ~mclk_in;
	ubie_core dut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .ep_en_in(ep_en),
		.dir_in_in(dir), .ping_pong_in(pp), .fw_wr_in(fw_wr), .fw_wdata_in(fw_wdata),
		.fw_rd_in(fw_rd), .fw_clr_rx0_in(fw_s[4]), .fw_clr_rx1_in(fw_s[3]),
		.fw_set_tx_packet_ready_in(fw_s[2]), .fw_clr_tx_packet_ready_in(fw_s[1]), .fw_clr_txdone_in(fw_s[0]),
		.fw_rdata_out(rdata), .flags_out(flags), .byte_cnt_out(cnt), .out_tok_in(out_tok),
		.in_tok_in(in_tok), .rx_vld_in(rx_vld), .rx_byte_in(rx_byte), .rx_end_in(rx_end),
		.rx_crc_ok_in(crc), .host_ack_in(hack), .host_tmo_in(htmo), .tx_ready_in(txr),
		.hs_out(hs), .tx_vld_out(tx_vld), .tx_data_out(tx_data), .tx_eop_out(tx_eop));
	ubie_host h (.mclk_in(mclk_in), .hs_in(hs), .tx_vld_in(tx_vld), .tx_data_in(tx_data),
		.tx_eop_in(tx_eop), .out_tok_out(out_tok), .in_tok_out(in_tok), .rx_vld_out(rx_vld),
		.rx_byte_out(rx_byte), .rx_end_out(rx_end), .rx_crc_ok_out(crc),
		.host_ack_out(hack), .host_tmo_out(htmo), .tx_ready_out(txr));
	always @(posedge mclk_in)
		if (hs.valid === 1'b1)
			hsq.push_back(hs.pid);
	function automatic logic [7:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction
	task print_verdict();
		$display("errors=%0d n_tests=%0d", errors, n_tests);
		if (errors == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task strobe(input logic [4:0] m);
		@(posedge mclk_in) fw_s <= m;
		@(posedge mclk_in) fw_s <= 5'h00;
		repeat (2) @(posedge mclk_in);
	endtask
	task hs_is(input logic [3:0] p);
		logic [3:0] q;
		`CHK(hsq.size(), 1)
		if (hsq.size() > 0) begin
			q = hsq.pop_front();
			`CHK(q, p)
		end
		hsq.delete();
	endtask
	task out_pkt(input int n, input logic ok, input logic keep, input logic ackd);
		d.delete();
		repeat (n) d.push_back(rnd());
		h.txq = d;
		if (keep)
			ex = {ex, d};
		h.send_out(ok);
		repeat (3) @(posedge mclk_in);
		hs_is(ackd ? `UBIE_PID_ACK : `UBIE_PID_NAK);
		tog = tog ^ ackd;
	endtask
	task rd_chk(input int n);
		repeat (n) begin
			@(posedge mclk_in) fw_rd <= 1'b1;
			@(posedge mclk_in) fw_rd <= 1'b0;
			@(posedge mclk_in) e = ex.pop_front();
			`CHK(rdata, e)
		end
	endtask
	task wr_all(input int n);
		repeat (n) begin
			e = rnd();
			ex.push_back(e);
			@(posedge mclk_in) fw_wr <= 1'b1;
			fw_wdata <= e;
			@(posedge mclk_in) fw_wr <= 1'b0;
		end
	endtask
	task in_chk(input logic ack, input logic exp_nak, input int n);
		int i;
		logic hung;
		h.in_xfer(ack, nak, hung);
		// the handshake monitor logs at this edge too; let it settle first
		@(posedge mclk_in);
		if (hung) begin
			errors++;
			print_verdict();
		end else begin
			`CHK(nak, exp_nak)
			if (exp_nak)
				hs_is(`UBIE_PID_NAK);
			else begin
				hs_is(tog ? `UBIE_PID_DATA1 : `UBIE_PID_DATA0);
				`CHK(h.got.size(), n)
				for (i = 0; i < n; i++)
					`CHK(h.got[i], ex[i])
				if (ack) begin
					tog = ~tog;
					repeat (n) void'(ex.pop_front());
				end
			end
			repeat (3) @(posedge mclk_in);
		end
	endtask
	initial begin
		repeat (100000) @(posedge mclk_in);
		errors++;
		print_verdict();
	end
	initial begin
		repeat (10) @(posedge mclk_in);
		sys_rst_in <= 1'b0;
		h.txq = {8'h5a};
		h.send_out(1'b1);
		repeat (3) @(posedge mclk_in);
		`CHK(hsq.size(), 0)
		`CHK(flags, 4'h0)
		ep_en <= 1'b1;
		out_pkt(5, 1'b1, 1'b1, 1'b1);
		`CHK(flags, 4'h8)
		out_pkt(3, 1'b1, 1'b0, 1'b0);
		rd_chk(5);
		`CHK(cnt, 16'h0005)
		strobe(5'h10);
		out_pkt(0, 1'b1, 1'b1, 1'b1);
		`CHK(cnt, 16'h0000)
		strobe(5'h10);
		out_pkt(70, 1'b1, 1'b1, 1'b1);
		`CHK(cnt, 16'h0046)
		rd_chk(64);
		ex.delete();
		strobe(5'h10);
		h.txq = {8'h11, 8'h22};
		h.send_out(1'b0);
		repeat (3) @(posedge mclk_in);
		`CHK(hsq.size(), 0)
		`CHK(flags, 4'h0)
		pp <= 1'b1;
		out_pkt(4, 1'b1, 1'b1, 1'b1);
		out_pkt(6, 1'b1, 1'b1, 1'b1);
		`CHK(flags, 4'hc)
		out_pkt(2, 1'b1, 1'b0, 1'b0);
		rd_chk(4);
		strobe(5'h10);
		`CHK(flags, 4'h4)
		`CHK(cnt, 16'h0006)
		rd_chk(6);
		strobe(5'h08);
		dir <= 1'b1;
		pp <= 1'b0;
		in_chk(1'b1, 1'b1, 0);
		wr_all(3);
		strobe(5'h04);
		`CHK(flags, 4'h2)
		in_chk(1'b0, 1'b0, 3);
		in_chk(1'b1, 1'b0, 3);
		`CHK(flags, 4'h1)
		strobe(5'h01);
		strobe(5'h04);
		in_chk(1'b1, 1'b0, 0);
		strobe(5'h01);
		wr_all(2);
		strobe(5'h04);
		strobe(5'h02);
		`CHK(flags, 4'h0)
		ex.delete();
		in_chk(1'b1, 1'b1, 0);
		wr_all(2);
		strobe(5'h04);
		in_chk(1'b1, 1'b0, 2);
		strobe(5'h01);
		pp <= 1'b1;
		wr_all(2);
		strobe(5'h04);
		wr_all(3);
		strobe(5'h04);
		in_chk(1'b1, 1'b0, 2);
		in_chk(1'b1, 1'b0, 3);
		`CHK(flags, 4'h1)
		in_chk(1'b1, 1'b1, 0);
		print_verdict();
	end
endmodule // usb_bulk_int_endpoint_xfer_tb
